// file: hdl/qdc_pkg.sv
// qdc_pkg: shared constants for the quad dac command and update controller.
// assumes both link ends and the bench refer to these names through qdc_pkg::.
package qdc_pkg;
    localparam int CMD_W    = 24;
    localparam int CODE_W   = 14;
    localparam int NUM_CH   = 4;
    localparam int LEVEL_W  = 16;
    // command word fields
    localparam int RW_BIT   = 23;
    localparam int ZERO_BIT = 22;
    localparam int REG_MSB  = 21;
    localparam int REG_LSB  = 19;
    localparam int ADR_MSB  = 18;
    localparam int ADR_LSB  = 16;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 2;
    localparam int CG_W     = 2;
    localparam int FG_W     = 6;
    localparam logic [2:0] REG_FUNC  = 3'h0;
    localparam logic [2:0] REG_DATA  = 3'h2;
    localparam logic [2:0] REG_CGAIN = 3'h3;
    localparam logic [2:0] REG_FGAIN = 3'h4;
    localparam logic [2:0] ADR_ALL   = 3'h4;
    localparam logic [2:0] FN_CLEAR  = 3'h4;
    localparam logic [2:0] FN_LOAD   = 3'h5;
    // coding and transfer function
    localparam logic [CODE_W-1:0]  MIDSCALE   = 14'h2000;
    localparam logic [CODE_W-1:0]  CLEAR_OB   = 14'h0000;
    localparam logic [CODE_W-1:0]  CLEAR_TC   = 14'h0000;
    localparam int                 CODE_RANGE = 16384;
    localparam logic [LEVEL_W-1:0] LEVEL_OFS  = 16'h8000;
    // pin synchroniser reset levels: {coding, clear_n, load_n, data, sclk, fsync_n}
    localparam logic [5:0] DEV_SYNC_RST = 6'h1B;
    // host register map, byte addresses
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [1:0] CTRL_RST   = 2'h3;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // serial clock timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SCLK_PERIOD_NS = 200;
    localparam int SCLK_HALF      = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage : qdc_pkg

// file: hdl/qdc_link_if.sv
// qdc_link_if: the serial command link between the controller and the dac.
// assumes the controller end drives every wire and the dac end only listens.
`timescale 1ns/1ps
interface qdc_link_if;
    logic frame_sync_n;
    logic serial_clk;
    logic serial_data_in;
    logic load_strobe_n;
    logic async_clear_n;

    modport ctrl (
        output frame_sync_n,
        output serial_clk,
        output serial_data_in,
        output load_strobe_n,
        output async_clear_n
    );
    modport dac (
        input frame_sync_n,
        input serial_clk,
        input serial_data_in,
        input load_strobe_n,
        input async_clear_n
    );
endinterface : qdc_link_if

// file: hdl/qdc_pin_sync.sv
// qdc_pin_sync: three-stage synchroniser with agreement filter per bit.
// assumes pins are asynchronous to clk_sys_in; output moves once stages 2 and 3 agree.
`timescale 1ns/1ps
module qdc_pin_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_sys_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] agree;

    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            stage1    <= RST;
            stage2    <= RST;
            stage3    <= RST;
            level_out <= RST;
        end
        else
        begin
            stage1    <= pin_in;
            stage2    <= stage1;
            stage3    <= stage2;
            level_out <= (stage3 & agree) | (level_out & ~agree);
        end
    end
endmodule : qdc_pin_sync

// file: hdl/qdc_dac_end.sv
// qdc_dac_end: command decode and output update logic of the quad dac.
// assumes the link wires arrive asynchronously; coding_select_in is a static strap pin.
`timescale 1ns/1ps
module qdc_dac_end (
    input  wire logic                    clk_sys_in,
    input  wire logic                    srst_in,
    qdc_link_if.dac                      link,
    input  wire logic                    coding_select_in,
    output logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::CODE_W-1:0]  chan_code_out,
    output logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::LEVEL_W-1:0] chan_level_out,
    output logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::CG_W-1:0]    coarse_gain_out,
    output logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::FG_W-1:0]    fine_gain_out,
    output logic                         frame_done_out,
    output logic                         frame_error_out,
    output logic                         read_request_out
);
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(qdc_pkg::CMD_W);
    localparam logic [CNT_W-1:0] CNT_OVER = CNT_W'(qdc_pkg::CMD_W + 1);

    logic [5:0]                  pins_sync;
    logic                        fsync_n;
    logic                        sclk;
    logic                        sdata;
    logic                        load_n;
    logic                        clear_n;
    logic                        coding_ob;
    logic                        fsync_q;
    logic                        sclk_q;
    logic                        load_q;
    logic                        fsync_fall;
    logic                        fsync_rise;
    logic                        sclk_fall;
    logic                        load_fall;
    logic [qdc_pkg::CMD_W-1:0]   shift_word;
    logic [CNT_W-1:0]            edge_cnt;
    logic                        load_low_frame;
    logic                        word_ok;
    logic                        word_write;
    logic [2:0]                  reg_sel;
    logic [2:0]                  chan_addr;
    logic [qdc_pkg::CODE_W-1:0]  new_code;
    logic                        wr_data;
    logic                        wr_cgain;
    logic                        wr_fgain;
    logic                        sw_clear;
    logic                        sw_load;
    logic                        clearing;
    logic [qdc_pkg::CODE_W-1:0]  clear_code;

    // a channel is hit by its own address or by the broadcast address
    function automatic logic chan_hit(input logic [2:0] addr, input int ch);
        chan_hit = (addr == qdc_pkg::ADR_ALL) || (addr == 3'(ch));
    endfunction : chan_hit

    // clear value follows the coding strap
    function automatic logic [qdc_pkg::CODE_W-1:0] clear_value(input logic ob);
        clear_value = ob ? qdc_pkg::CLEAR_OB : qdc_pkg::CLEAR_TC;
    endfunction : clear_value

    qdc_pin_sync #(
        .W   (6),
        .RST (qdc_pkg::DEV_SYNC_RST)
    ) u_pin_sync (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .pin_in     ({coding_select_in, link.async_clear_n, link.load_strobe_n,
                      link.serial_data_in, link.serial_clk, link.frame_sync_n}),
        .level_out  (pins_sync)
    );

    assign fsync_n   = pins_sync[0];
    assign sclk      = pins_sync[1];
    assign sdata     = pins_sync[2];
    assign load_n    = pins_sync[3];
    assign clear_n   = pins_sync[4];
    assign coding_ob = pins_sync[5];

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            fsync_q <= 1'b1;
            sclk_q  <= 1'b1;
            load_q  <= 1'b1;
        end
        else
        begin
            fsync_q <= fsync_n;
            sclk_q  <= sclk;
            load_q  <= load_n;
        end
    end

    assign fsync_fall = fsync_q & ~fsync_n;
    assign fsync_rise = ~fsync_q & fsync_n;
    assign sclk_fall  = sclk_q & ~sclk & ~fsync_n;
    assign load_fall  = load_q & ~load_n;

    // shift register and falling-edge counter; the count saturates so long
    // frames stay distinguishable from exact ones
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            shift_word <= '0;
            edge_cnt   <= '0;
        end
        else if (fsync_fall)
        begin
            edge_cnt <= '0;
        end
        else if (sclk_fall)
        begin
            shift_word <= {shift_word[qdc_pkg::CMD_W-2:0], sdata};
            if (edge_cnt != CNT_OVER)
            begin
                edge_cnt <= edge_cnt + 1'b1;
            end
        end
    end

    // load level seen over the frame decides between the two update modes;
    // any high sample during shifting selects the simultaneous mode
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            load_low_frame <= 1'b0;
        end
        else if (fsync_fall)
        begin
            load_low_frame <= ~load_n;
        end
        else if (~fsync_n && load_n)
        begin
            load_low_frame <= 1'b0;
        end
    end

    assign word_ok    = fsync_rise && (edge_cnt == CNT_FULL);
    assign word_write = word_ok && !shift_word[qdc_pkg::RW_BIT]
                        && !shift_word[qdc_pkg::ZERO_BIT];
    assign reg_sel    = shift_word[qdc_pkg::REG_MSB:qdc_pkg::REG_LSB];
    assign chan_addr  = shift_word[qdc_pkg::ADR_MSB:qdc_pkg::ADR_LSB];
    assign new_code   = shift_word[qdc_pkg::CODE_MSB:qdc_pkg::CODE_LSB];
    assign wr_data    = word_write && (reg_sel == qdc_pkg::REG_DATA);
    assign wr_cgain   = word_write && (reg_sel == qdc_pkg::REG_CGAIN);
    assign wr_fgain   = word_write && (reg_sel == qdc_pkg::REG_FGAIN);
    assign sw_clear   = word_write && (reg_sel == qdc_pkg::REG_FUNC)
                        && (chan_addr == qdc_pkg::FN_CLEAR);
    assign sw_load    = word_write && (reg_sel == qdc_pkg::REG_FUNC)
                        && (chan_addr == qdc_pkg::FN_LOAD);
    // clear acts from the falling edge for as long as the pin stays low, so a
    // pin already low out of reset clears every channel too
    assign clearing   = ~clear_n || sw_clear;
    assign clear_code = clear_value(coding_ob);

    generate
        for (genvar ch = 0; ch < qdc_pkg::NUM_CH; ch++)
        begin : g_chan
            logic [qdc_pkg::CODE_W-1:0] input_code;
            logic [qdc_pkg::CODE_W-1:0] ob_code;

            always_ff @(posedge clk_sys_in)
            begin
                if (srst_in)
                begin
                    input_code        <= '0;
                    chan_code_out[ch] <= '0;
                end
                else if (clearing)
                begin
                    input_code        <= clear_code;
                    chan_code_out[ch] <= clear_code;
                end
                else if (wr_data && chan_hit(chan_addr, ch))
                begin
                    input_code <= new_code;
                    if (load_low_frame)
                    begin
                        chan_code_out[ch] <= new_code;
                    end
                end
                else if (load_fall || sw_load)
                begin
                    chan_code_out[ch] <= input_code;
                end
            end

            always_ff @(posedge clk_sys_in)
            begin
                if (srst_in)
                begin
                    coarse_gain_out[ch] <= '0;
                    fine_gain_out[ch]   <= '0;
                end
                else
                begin
                    if (wr_cgain && chan_hit(chan_addr, ch))
                    begin
                        coarse_gain_out[ch] <= shift_word[qdc_pkg::CG_W-1:0];
                    end
                    if (wr_fgain && chan_hit(chan_addr, ch))
                    begin
                        fine_gain_out[ch] <= shift_word[qdc_pkg::FG_W-1:0];
                    end
                end
            end

            // level in units of vref/16384: 4*D - 2*16384, D the offset-binary code
            assign ob_code = coding_ob ? chan_code_out[ch]
                                       : (chan_code_out[ch] ^ qdc_pkg::MIDSCALE);

            always_ff @(posedge clk_sys_in)
            begin
                if (srst_in)
                begin
                    chan_level_out[ch] <= qdc_pkg::LEVEL_OFS ^ qdc_pkg::LEVEL_OFS;
                end
                else
                begin
                    chan_level_out[ch] <= {ob_code, 2'b00} - qdc_pkg::LEVEL_OFS;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            frame_done_out   <= 1'b0;
            frame_error_out  <= 1'b0;
            read_request_out <= 1'b0;
        end
        else
        begin
            frame_done_out   <= word_ok;
            frame_error_out  <= fsync_rise && (edge_cnt != CNT_FULL);
            read_request_out <= word_ok && shift_word[qdc_pkg::RW_BIT];
        end
    end
endmodule : qdc_dac_end

// file: hdl/qdc_ctrl_end.sv
// qdc_ctrl_end: axi4-lite controlled serialiser driving the dac command link.
// assumes one axi4-lite master; the dac end listens on the link interface.
`timescale 1ns/1ps
module qdc_ctrl_end (
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    qdc_link_if.ctrl         link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [2:0] {S_IDLE, S_LEAD, S_LOW, S_HIGH, S_TRAIL, S_GAP} qdc_state_t;

    qdc_state_t                state;
    logic [7:0]                aw_addr;
    logic                      aw_have;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      w_have;
    logic                      do_write;
    logic                      start;
    logic [qdc_pkg::CMD_W-1:0] cmd_last;
    logic [qdc_pkg::CMD_W-1:0] shift_out;
    logic [4:0]                bit_cnt;
    logic [2:0]                half_cnt;
    logic                      tick;
    logic [1:0]                ctrl;

    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready  = !w_have && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_have && w_have && !s_axi_bvalid;
    // a command written while a frame is in flight is dropped, not queued
    assign start = do_write && (aw_addr == qdc_pkg::OFS_CMD) && (w_strb[2:0] == 3'h7)
                   && (state == S_IDLE);

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_have <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= qdc_pkg::RESP_OKAY;
            ctrl         <= qdc_pkg::CTRL_RST;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == qdc_pkg::OFS_CMD || aw_addr == qdc_pkg::OFS_CTRL)
                            ? qdc_pkg::RESP_OKAY : qdc_pkg::RESP_SLVERR;
            if (aw_addr == qdc_pkg::OFS_CTRL && w_strb[0])
            begin
                ctrl <= w_data[1:0];
            end
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= qdc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= qdc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                qdc_pkg::OFS_CMD:    s_axi_rdata <= {8'h00, cmd_last};
                qdc_pkg::OFS_CTRL:   s_axi_rdata <= {30'h0, ctrl};
                qdc_pkg::OFS_STATUS: s_axi_rdata <= {31'h0, state != S_IDLE};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= qdc_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // serial clock divider: one enable pulse per half period while busy
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in || state == S_IDLE)
        begin
            half_cnt <= '0;
        end
        else
        begin
            half_cnt <= tick ? 3'h0 : half_cnt + 3'h1;
        end
    end
    assign tick = (half_cnt == 3'(qdc_pkg::SCLK_HALF - 1));

    // clock idles high: data changes on the rising edge, dac samples on falling
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            state               <= S_IDLE;
            link.frame_sync_n   <= 1'b1;
            link.serial_clk     <= 1'b1;
            link.serial_data_in <= 1'b0;
            shift_out           <= '0;
            bit_cnt             <= '0;
            cmd_last            <= '0;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (start)
                    begin
                        cmd_last            <= w_data[qdc_pkg::CMD_W-1:0];
                        shift_out           <= w_data[qdc_pkg::CMD_W-1:0];
                        link.serial_data_in <= w_data[qdc_pkg::CMD_W-1];
                        link.frame_sync_n   <= 1'b0;
                        bit_cnt             <= '0;
                        state               <= S_LEAD;
                    end
                end
                S_LEAD, S_HIGH:
                begin
                    if (tick)
                    begin
                        link.serial_clk <= 1'b0;
                        bit_cnt         <= bit_cnt + 5'h1;
                        state           <= S_LOW;
                    end
                end
                S_LOW:
                begin
                    if (tick)
                    begin
                        link.serial_clk <= 1'b1;
                        if (bit_cnt == 5'(qdc_pkg::CMD_W))
                        begin
                            state <= S_TRAIL;
                        end
                        else
                        begin
                            shift_out           <= {shift_out[qdc_pkg::CMD_W-2:0], 1'b0};
                            link.serial_data_in <= shift_out[qdc_pkg::CMD_W-2];
                            state               <= S_HIGH;
                        end
                    end
                end
                S_TRAIL:
                begin
                    if (tick)
                    begin
                        link.frame_sync_n <= 1'b1;
                        state             <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    if (tick)
                    begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // strobe and clear pins are software levels; clear pulse width is timed by software
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            link.load_strobe_n <= 1'b1;
            link.async_clear_n <= 1'b1;
        end
        else
        begin
            link.load_strobe_n <= ctrl[0];
            link.async_clear_n <= ctrl[1];
        end
    end
endmodule : qdc_ctrl_end

// file: test/qdc_link_properties.sv
// qdc_link_properties: timing checks on the serial command link wires.
// assumes tb_top instantiates it beside the link interface; clock 40 MHz, frames from ctrl end.
`timescale 1ns/1ps
module qdc_link_properties (
    input  wire logic clk_sys_in,
    input  wire logic srst_in,
    input  wire logic frame_sync_n,
    input  wire logic serial_clk,
    input  wire logic serial_data_in
);
    // falling serial clock edges seen inside the current frame
    logic [5:0] falls;
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in || frame_sync_n)
            falls <= 6'h00;
        else if ($fell(serial_clk))
            falls <= falls + 6'h01;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    property p_count; $rose(frame_sync_n) |-> falls == 6'h18; endproperty
    a_count: assert property (p_count) else $error("frame without 24 clock falls");
    property p_idle; frame_sync_n |-> serial_clk; endproperty
    a_idle: assert property (p_idle) else $error("serial clock low outside frame");
    property p_low; $fell(serial_clk) |-> !serial_clk [*4] ##1 serial_clk; endproperty
    a_low: assert property (p_low) else $error("serial clock low phase wrong");
    property p_high; $rose(serial_clk) |-> serial_clk [*4]; endproperty
    a_high: assert property (p_high) else $error("serial clock high phase short");
    property p_start; $fell(frame_sync_n) |-> serial_clk [*4]; endproperty
    a_start: assert property (p_start) else $error("first clock fall too early");
    property p_gap; $rose(frame_sync_n) |-> frame_sync_n [*4]; endproperty
    a_gap: assert property (p_gap) else $error("frame gap too short");
    property p_end; $rose(frame_sync_n) |-> $past(serial_clk, 4) && !$past(serial_clk, 5); endproperty
    a_end: assert property (p_end) else $error("frame end not 4 cycles after last rise");
    property p_data; $changed(serial_data_in) && !frame_sync_n && !$past(frame_sync_n)
        |-> $rose(serial_clk); endproperty
    a_data: assert property (p_data) else $error("data moved off a clock rise");
endmodule : qdc_link_properties

// file: test/tb_top.sv
// tb_top: axi4-lite driven bench of both link ends joined by qdc_link_if.
// assumes the design files and qdc_pkg are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        coding = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, done, ferr, rreq;
    logic [1:0]  bresp, rresp;
    logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::CODE_W-1:0]  code, exp;
    logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::LEVEL_W-1:0] level;
    logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::CG_W-1:0]    cg;
    logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::FG_W-1:0]    fg;
    int          err_count = 0, cmp_count = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    qdc_link_if link ();
    qdc_ctrl_end i_qdc_ctrl_end (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .link(link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    qdc_dac_end i_qdc_dac_end (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .link(link),
        .coding_select_in(coding), .chan_code_out(code), .chan_level_out(level),
        .coarse_gain_out(cg), .fine_gain_out(fg), .frame_done_out(done),
        .frame_error_out(ferr), .read_request_out(rreq));
    qdc_link_properties i_qdc_link_properties (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .frame_sync_n(link.frame_sync_n), .serial_clk(link.serial_clk),
        .serial_data_in(link.serial_data_in));
    task stop_test;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // ready is read right after the edge, so it is the value that edge sampled
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit fin = 1'b0;
        @(posedge clk_sys_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!fin)
        begin
            @(posedge clk_sys_in);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                bready <= 1'b0;
                fin = 1'b1;
                chk("bresp", r, bresp);
            end
        end
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        bit fin = 1'b0;
        @(posedge clk_sys_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!fin)
        begin
            @(posedge clk_sys_in);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                rready <= 1'b0;
                d = rdata;
                fin = 1'b1;
            end
        end
    endtask : axr
    task send(input logic [23:0] w);
        int n;
        axw(qdc_pkg::OFS_CMD, {8'h00, w}, qdc_pkg::RESP_OKAY);
        for (n = 0; n < 600 && done !== 1'b1 && ferr !== 1'b1; n++)
            @(posedge clk_sys_in);
        chk("frame_end_err_read", {1'b1, 1'b0, w[23]}, {n < 600, ferr, rreq});
        repeat (8) @(posedge clk_sys_in);
    endtask : send
    task ctl(input logic [1:0] v);
        axw(qdc_pkg::OFS_CTRL, {30'h0, v}, qdc_pkg::RESP_OKAY);
        repeat (10) @(posedge clk_sys_in);
    endtask : ctl
    task dw(input logic [2:0] ch, input logic [13:0] c, input bit upd);
        send({2'h0, qdc_pkg::REG_DATA, ch, c, 2'h3});
        if (upd && ch == qdc_pkg::ADR_ALL)
            exp = {qdc_pkg::NUM_CH{c}};
        else if (upd)
            exp[ch[1:0]] = c;
        chk("codes", exp, code);
    endtask : dw
    initial
    begin
        exp = '0;
        repeat (20) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        chk("codes_rst", 0, code);
        axr(qdc_pkg::OFS_CTRL, rd);
        chk("ctrl_rst", qdc_pkg::CTRL_RST, rd);
        axw(8'h0C, 32'h0, qdc_pkg::RESP_SLVERR);
        ctl(2'h2);
        for (int i = 0; i < 5; i++)
        begin
            dw(i[2:0], {i[3:0], 10'h2A5}, 1'b1);
            chk("level", {exp[i & 3], 2'h0} ^ 16'h8000, level[i & 3]);
        end
        ctl(2'h3);
        dw(3'h0, 14'h3FFF, 1'b0);
        ctl(2'h2);
        exp[0] = 14'h3FFF;
        chk("codes", exp, code);
        send(24'hA11234);
        chk("codes", exp, code);
        axr(qdc_pkg::OFS_CMD, rd);
        chk("cmd_rb", 32'h00A11234, rd);
        send({2'h0, qdc_pkg::REG_CGAIN, 3'h2, 16'h0002});
        chk("cgain", 2'h2, cg[2]);
        send({2'h0, qdc_pkg::REG_FGAIN, 3'h1, 16'h002A});
        chk("fgain", 6'h2A, fg[1]);
        ctl(2'h3);
        dw(3'h3, 14'h0AAA, 1'b0);
        send({2'h0, qdc_pkg::REG_FUNC, qdc_pkg::FN_LOAD, 16'h0000});
        exp[3] = 14'h0AAA;
        chk("codes", exp, code);
        send(24'h04ABCD);
        exp = '0;
        chk("codes", exp, code);
        ctl(2'h2);
        dw(3'h1, 14'h1111, 1'b1);
        send(24'h503FFC);
        chk("codes", exp, code);
        ctl(2'h0);
        chk("codes", 0, code);
        ctl(2'h2);
        chk("codes", 0, code);
        coding <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        chk("level_tc", 16'h0000, level[0]);
        stop_test();
    end
    initial
    begin
        #(25 * 40000);
        err_count++;
        stop_test();
    end
endmodule : tb_top
